// [dv/isra_master.sv]
// two-wire bus master model driving the slave pins
`timescale 1ns/1ps
module isra_master (
    // clock
    input wire logic core_clk_i,
    // bus lines
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic q;
        repeat (8) @(posedge core_clk_i);
        #1;
    endtask : q
    task automatic clk_bit(input logic b, output logic s);
        sda_o = b;
        q();
        scl_o = 1'b1;
        q();
        s = sda_i;
        q();
        scl_o = 1'b0;
        q();
    endtask : clk_bit
    task automatic start;
        sda_o = 1'b1;
        q();
        scl_o = 1'b1;
        q();
        sda_o = 1'b0;
        q();
        scl_o = 1'b0;
        q();
    endtask : start
    task automatic stop;
        sda_o = 1'b0;
        q();
        scl_o = 1'b1;
        q();
        sda_o = 1'b1;
        q();
    endtask : stop
    task automatic wbyte(input logic [7:0] d, output logic ak);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ak = ~s;
    endtask : wbyte
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(last, s);
    endtask : rbyte
endmodule : isra_master

// [dv/isra_slave_tb_top.sv]
// bench for the two-wire register access front end
`timescale 1ns/1ps
`include "isra_defines.svh"
module isra_slave_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic strap = 1'b0;
    logic shut_req = 1'b0;
    logic wr_ready = 1'b1;
    logic ce = 1'b1;
    logic m_scl, m_sda, sda_o, sda_oe_n, rd_strobe, wr_valid, dev_rst, bus_shut, ak;
    logic [7:0] rd_addr, rd_data, wr_addr, wr_data;
    wire sda_w;
    int mismatches = 0;
    int n_compared = 0;
    int n_rst = 0;
    int n_rd = 0;
    logic [15:0] words[$];
    always #2.5 clk = ~clk;
    assign sda_w = m_sda & (sda_oe_n | sda_o);
    assign rd_data = regv(rd_addr);
    always @(posedge clk) begin
        if (wr_valid === 1'b1 && wr_ready) words.push_back({wr_addr, wr_data});
        if (dev_rst === 1'b1) n_rst++;
        if (rd_strobe === 1'b1) n_rd++;
    end
    isra_master u_m (.core_clk_i(clk), .sda_i(sda_w), .scl_o(m_scl), .sda_o(m_sda));
    isra_slave u_dut (.core_clk_i(clk), .reset_i(rst), .ce_i(ce), .scl_i(m_scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n),
        .slave_address_select_input_i(strap), .bus_interface_shutdown_i(shut_req),
        .rd_addr_o(rd_addr), .rd_data_i(rd_data), .rd_strobe_o(rd_strobe),
        .wr_valid_o(wr_valid), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
        .wr_ready_i(wr_ready), .dev_reset_o(dev_rst), .bus_shut_o(bus_shut));
    function automatic logic [7:0] regv(input logic [7:0] a);
        case (a)
            8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h09, 8'h10, 8'h11, 8'h12: return a ^ 8'h5a;
            default: return 8'h00;
        endcase
    endfunction : regv
    function automatic logic [7:0] nxt(input logic [7:0] a);
        if (a == `ISRA_NOINC_REG) return a;
        if (a >= `ISRA_LAST_REG) return 8'h00;
        return a + 8'h01;
    endfunction : nxt
    task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk_word
    task automatic chk_bit(input logic g, input logic e);
        chk_word({15'h0000, g}, {15'h0000, e});
    endtask : chk_bit
    task automatic do_reset;
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        repeat (6) @(posedge clk);
        #1;
    endtask : do_reset
    task automatic acc(input logic [7:0] p, input logic [6:0] dev, output logic ok);
        logic a1, a2;
        u_m.start();
        u_m.wbyte({dev, 1'b0}, a1);
        u_m.wbyte(p, a2);
        ok = a1 & a2;
    endtask : acc
    task automatic rd_seq(input logic [7:0] p, input int n);
        logic [7:0] a, d;
        int s0;
        a = p;
        s0 = n_rd;
        acc(p, `ISRA_DEV_SLAVE_ADDRESS_SELECT_INPUT, ak);
        chk_bit(ak, 1'b1);
        u_m.start();
        u_m.wbyte({`ISRA_DEV_SLAVE_ADDRESS_SELECT_INPUT, 1'b1}, ak);
        chk_bit(ak, 1'b1);
        for (int i = 0; i < n; i++) begin
            u_m.rbyte(i == n - 1, d);
            chk_word({8'h00, d}, {8'h00, regv(a)});
            a = nxt(a);
        end
        chk_bit(sda_oe_n, 1'b1);
        u_m.stop();
        repeat (40) @(posedge clk);
        #1;
        chk_word({8'h00, rd_addr}, {8'h00, a});
        chk_word(16'(n_rd - s0), 16'(n));
    endtask : rd_seq
    task automatic wr_seq(input logic [7:0] p, input int n, input int n_ack);
        acc(p, `ISRA_DEV_SLAVE_ADDRESS_SELECT_INPUT, ak);
        chk_bit(ak, 1'b1);
        for (int i = 0; i < n; i++) begin
            u_m.wbyte(8'hc0 + 8'(i), ak);
            chk_bit(ak, i < n_ack);
        end
        u_m.stop();
    endtask : wr_seq
    task automatic chk_words(input logic [7:0] p, input int n);
        for (int i = 0; i < 60 && wr_valid !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        chk_word(16'(words.size()), 16'(n));
        for (int i = 0; i < n && words.size() > 0; i++) begin
            chk_word(words.pop_front(), {p, 8'hc0 + 8'(i)});
            p = nxt(p);
        end
    endtask : chk_words
    task automatic gc(input logic [7:0] cmd);
        acc(cmd, 7'h00, ak);
        u_m.stop();
        chk_bit(ak, 1'b1);
    endtask : gc
    task automatic t_write;
        wr_seq(8'h11, 3, 3);
        chk_words(8'h11, 3);
        wr_seq(`ISRA_NOINC_REG, 2, 2);
        chk_words(`ISRA_NOINC_REG, 2);
        wr_seq(8'h03, 1, 1);
        chk_words(8'h03, 0);
    endtask : t_write
    task automatic t_read;
        rd_seq(8'h10, 4);
        rd_seq(`ISRA_NOINC_REG, 2);
        rd_seq(8'h03, 1);
    endtask : t_read
    task automatic t_full;
        wr_ready = 1'b0;
        wr_seq(`ISRA_NOINC_REG, 9, `ISRA_FIFO_DEPTH);
        chk_bit(wr_valid, 1'b1);
        wr_ready = 1'b1;
        chk_words(`ISRA_NOINC_REG, `ISRA_FIFO_DEPTH);
    endtask : t_full
    task automatic t_gc;
        ce = 1'b0;
        acc(8'h00, `ISRA_DEV_SLAVE_ADDRESS_SELECT_INPUT, ak);
        u_m.stop();
        ce = 1'b1;
        chk_bit(ak, 1'b0);
        acc(8'h00, `ISRA_DEV_ADDR1, ak);
        u_m.stop();
        chk_bit(ak, 1'b0);
        strap = 1'b1;
        gc(`ISRA_GC_LATCH);
        chk_word(16'(n_rst), 16'h0000);
        strap = 1'b0;
        gc(8'h05);
        chk_word(16'(n_rst), 16'h0000);
        acc(8'h11, `ISRA_DEV_ADDR1, ak);
        u_m.stop();
        chk_bit(ak, 1'b1);
        gc(`ISRA_GC_RESET);
        chk_word(16'(n_rst), 16'h0001);
        chk_word({8'h00, rd_addr}, 16'h0000);
        acc(8'h00, `ISRA_DEV_SLAVE_ADDRESS_SELECT_INPUT, ak);
        u_m.stop();
        chk_bit(ak, 1'b1);
    endtask : t_gc
    task automatic t_shut;
        shut_req = 1'b1;
        acc(8'h00, `ISRA_DEV_SLAVE_ADDRESS_SELECT_INPUT, ak);
        u_m.stop();
        chk_bit(ak, 1'b0);
        chk_bit(bus_shut, 1'b1);
        shut_req = 1'b0;
        acc(8'h00, `ISRA_DEV_SLAVE_ADDRESS_SELECT_INPUT, ak);
        u_m.stop();
        chk_bit(ak, 1'b0);
        do_reset();
        chk_bit(bus_shut, 1'b0);
        acc(8'h00, `ISRA_DEV_SLAVE_ADDRESS_SELECT_INPUT, ak);
        u_m.stop();
        chk_bit(ak, 1'b1);
    endtask : t_shut
    task automatic results;
        $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    initial begin
        #400000;
        mismatches++;
        results();
    end
    initial begin
        do_reset();
        t_write();
        t_read();
        t_full();
        t_gc();
        t_shut();
        results();
    end
endmodule : isra_slave_tb_top

// [hdl/isra_fifo.sv]
// write-path buffer with valid/ready on both sides
`timescale 1ns/1ps
module isra_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and control
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // filling side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // draining side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_param
        $error("isra_fifo: depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic not_full;
        logic not_empty;
    } isra_fifo_state_type;

    isra_fifo_state_type st_reg;
    isra_fifo_state_type st_next;
    logic do_in;
    logic do_out;

    always_comb begin
        st_next = st_reg;
        do_in = in_valid_i && st_reg.not_full;
        do_out = out_ready_i && st_reg.not_empty;
        if (do_in) begin
            st_next.mem[st_reg.wp] = in_data_i;
            st_next.wp = st_reg.wp + 1'b1;
        end
        if (do_out) begin
            st_next.rp = st_reg.rp + 1'b1;
        end
        st_next.cnt = st_reg.cnt + {{AW{1'b0}}, do_in} - {{AW{1'b0}}, do_out};
        st_next.not_full = st_next.cnt != DEPTH[AW:0];
        st_next.not_empty = st_next.cnt != '0;
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_reg <= '0;
            st_reg.not_full <= 1'b1;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    assign in_ready_o = st_reg.not_full;
    assign out_valid_o = st_reg.not_empty;
    assign out_data_o = st_reg.mem[st_reg.rp];
endmodule : isra_fifo

// [hdl/isra_slave.sv]
// two-wire slave front end giving register access to the port expander
// Notes on behaviour
// - each access begins with write-addressed slave taking a register pointer byte.
// - reads need repeated start and read-addressed slave; device acks then sends byte.
// - a released acknowledge slot after a sent byte returns the slave to idle.
// - in an incrementing range the pointer advances after every byte sent.
// - after the last register a sequential read wraps to register zero.
// - in a non-incrementing range every read byte repeats one register.
// - after the pointer byte each data byte is acked, but only implemented registers store it; a full buffer gives no ack.
// - several data bytes may follow; pointer advance depends on its range.
// - writes past the last register wrap the pointer on the next byte.
// - general call address zero with write is acked; next byte is a command.
// - command 0x06 resets the device and relatches the address strap.
// - command 0x04 relatches the address strap without reset.
// - zero command is forbidden to master; other commands do nothing.
// - state only advances on bus clock edges and bus conditions.
// - shutdown request takes effect at the next bus clock rising edge.
// - while shut down all bus traffic is ignored, own address too.
// - only the hardware reset input brings the shut interface back.
// - own address is acked in the ninth slot; mismatch stays off the bus.
// - shutdown bit lives in system control, resets to zero, set by one.
`timescale 1ns/1ps
`include "isra_defines.svh"
module isra_slave import isra_pkg::*; #(
    parameter int FIFO_DEPTH = `ISRA_FIFO_DEPTH
) (
    // clock and control
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // two-wire bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    // address strap pin
    input wire logic slave_address_select_input_i,
    // register file side
    input wire logic bus_interface_shutdown_i,
    output logic [7:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    output logic rd_strobe_o,
    output logic wr_valid_o,
    output logic [7:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    input wire logic wr_ready_i,
    output logic dev_reset_o,
    output logic bus_shut_o
);
    if (FIFO_DEPTH < 2) begin : g_bad_depth
        $error("isra_slave: write buffer depth below 2");
    end

    isra_slave_state_type r;
    isra_slave_state_type n;
    logic [1:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic sel_s;
    logic fifo_ready;
    logic [15:0] fifo_word;
    logic rise;
    logic fall;
    logic start_c;
    logic stop_c;
    logic [6:0] own_addr;

    // bus pins and strap pass two flops
    isra_sync #(.WIDTH(2), .INIT(2'h3)) u_sync_bus (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .async_i({scl_i, sda_i}),
        .sync_o(pins_s)
    );

    isra_sync #(.WIDTH(1), .INIT(1'h0)) u_sync_sel (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .async_i(slave_address_select_input_i),
        .sync_o(sel_s)
    );

    isra_fifo #(.WIDTH(`ISRA_WORD_BITS), .DEPTH(FIFO_DEPTH)) u_wr_fifo (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .in_valid_i(r.push),
        .in_data_i(r.push_word),
        .in_ready_o(fifo_ready),
        .out_valid_o(wr_valid_o),
        .out_data_o(fifo_word),
        .out_ready_i(wr_ready_i)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    // registers that answer with real contents
    function automatic logic implemented(input logic [7:0] a);
        unique case (a)
            8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h09, 8'h10, 8'h11, 8'h12: implemented = 1'b1;
            default: implemented = 1'b0;
        endcase
    endfunction : implemented

    // pointer step after a byte, shared by reads and writes
    function automatic logic [7:0] advance(input logic [7:0] a);
        if (a == `ISRA_NOINC_REG) begin
            advance = a;
        end else if (a >= `ISRA_LAST_REG) begin
            advance = `ISRA_FIRST_REG;
        end else begin
            advance = a + 8'h01;
        end
    endfunction : advance

    // fetch a register byte and drive its first bit
    function automatic isra_slave_state_type load_send(input isra_slave_state_type s,
                                                      input logic [7:0] d);
        isra_slave_state_type t;
        t = s;
        t.shift = implemented(s.ptr) ? d : 8'h00;
        t.sda_oe_n = t.shift[7];
        t.ptr = advance(s.ptr);
        t.rd_strobe = 1'b1;
        t.phase = ISRA_SEND;
        t.bitcnt = 4'h0;
        return t;
    endfunction : load_send

    assign own_addr = r.addr_sel ? `ISRA_DEV_ADDR1 : `ISRA_DEV_SLAVE_ADDRESS_SELECT_INPUT;
    assign rise = scl_s && !r.scl_d;
    assign fall = !scl_s && r.scl_d;
    assign start_c = scl_s && r.scl_d && r.sda_d && !sda_s;
    assign stop_c = scl_s && r.scl_d && !r.sda_d && sda_s;

    always_comb begin
        n = r;
        n.dev_reset = 1'b0;
        n.rd_strobe = 1'b0;
        n.push = 1'b0;
        n.scl_d = scl_s;
        n.sda_d = sda_s;
        if (!r.strap_taken) begin
            n.addr_sel = sel_s;
            n.strap_taken = 1'b1;
        end
        if (r.shut) begin
            n.phase = ISRA_IDLE;
            n.sda_oe_n = 1'b1;
        end else if (rise && bus_interface_shutdown_i) begin
            n.shut = 1'b1;
            n.phase = ISRA_IDLE;
            n.sda_oe_n = 1'b1;
        end else if (start_c) begin
            n.phase = ISRA_RECV;
            n.kind = ISRA_K_ADDR;
            n.bitcnt = 4'h0;
            n.sda_oe_n = 1'b1;
        end else if (stop_c) begin
            n.phase = ISRA_IDLE;
            n.sda_oe_n = 1'b1;
        end else begin
            unique case (r.phase)
                ISRA_IDLE, ISRA_IGNORE: begin
                    n.sda_oe_n = 1'b1;
                end
                ISRA_RECV: begin
                    if (rise) begin
                        n.shift = {r.shift[6:0], sda_s};
                        n.bitcnt = r.bitcnt + 4'h1;
                    end else if (fall && r.bitcnt == `ISRA_BYTE_BITS) begin
                        n.phase = ISRA_ACK;
                        n.sda_oe_n = 1'b0;
                        unique case (r.kind)
                            ISRA_K_ADDR: begin
                                if (r.shift[7:1] == own_addr) begin
                                    n.kind = r.shift[0] ? ISRA_K_READ : ISRA_K_REG;
                                end else if (r.shift == `ISRA_GC_ADDR) begin
                                    n.kind = ISRA_K_GC;
                                end else begin
                                    n.phase = ISRA_IGNORE;
                                    n.sda_oe_n = 1'b1;
                                end
                            end
                            ISRA_K_REG: begin
                                n.ptr = r.shift;
                                n.kind = ISRA_K_DATA;
                            end
                            ISRA_K_DATA: begin
                                if (!implemented(r.ptr)) begin
                                    n.ptr = advance(r.ptr);
                                end else if (fifo_ready) begin
                                    n.push = 1'b1;
                                    n.push_word = {r.ptr, r.shift};
                                    n.ptr = advance(r.ptr);
                                end else begin
                                    n.phase = ISRA_IGNORE;
                                    n.sda_oe_n = 1'b1;
                                end
                            end
                            ISRA_K_GC: begin
                                n.kind = ISRA_K_NONE;
                                if (r.shift == `ISRA_GC_RESET) begin
                                    n.addr_sel = sel_s;
                                    n.ptr = `ISRA_FIRST_REG;
                                    n.dev_reset = 1'b1;
                                end else if (r.shift == `ISRA_GC_LATCH) begin
                                    n.addr_sel = sel_s;
                                end
                            end
                            default: begin
                                n.phase = ISRA_IGNORE;
                                n.sda_oe_n = 1'b1;
                            end
                        endcase
                    end
                end
                ISRA_ACK: begin
                    if (fall) begin
                        n.sda_oe_n = 1'b1;
                        n.bitcnt = 4'h0;
                        if (r.kind == ISRA_K_READ) begin
                            n = load_send(n, rd_data_i);
                        end else begin
                            n.phase = ISRA_RECV;
                        end
                    end
                end
                ISRA_SEND: begin
                    if (rise) begin
                        n.bitcnt = r.bitcnt + 4'h1;
                    end else if (fall) begin
                        if (r.bitcnt == `ISRA_BYTE_BITS) begin
                            n.sda_oe_n = 1'b1;
                            n.phase = ISRA_MACK;
                        end else begin
                            n.shift = {r.shift[6:0], 1'b0};
                            n.sda_oe_n = r.shift[6];
                        end
                    end
                end
                ISRA_MACK: begin
                    if (rise) begin
                        if (sda_s) begin
                            n.phase = ISRA_IDLE;
                        end else begin
                            n.bitcnt = `ISRA_ACKED;
                        end
                    end else if (fall && r.bitcnt == `ISRA_ACKED) begin
                        n = load_send(n, rd_data_i);
                    end
                end
                default: begin
                    n.phase = ISRA_IDLE;
                    n.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            r <= '0;
            r.phase <= ISRA_IDLE;
            r.kind <= ISRA_K_NONE;
            r.sda_oe_n <= 1'b1;
            r.scl_d <= 1'b1;
            r.sda_d <= 1'b1;
        end else if (ce_i) begin
            r <= n;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_n_o = r.sda_oe_n;
    assign rd_addr_o = r.ptr;
    assign rd_strobe_o = r.rd_strobe;
    assign wr_addr_o = fifo_word[15:8];
    assign wr_data_o = fifo_word[7:0];
    assign dev_reset_o = r.dev_reset;
    assign bus_shut_o = r.shut;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    property p_ack_own;
        ce_i && !r.shut && !bus_interface_shutdown_i && !start_c && !stop_c
            && r.phase == ISRA_RECV && r.kind == ISRA_K_ADDR && fall
            && r.bitcnt == 4'h8 && r.shift[7:1] == own_addr
            |=> !sda_oe_n_o && r.phase == ISRA_ACK;
    endproperty
    a_ack_own: assert property (p_ack_own) else $error("own address not acked");
    property p_mismatch_quiet;
        ce_i && !r.shut && !bus_interface_shutdown_i && !start_c && !stop_c
            && r.phase == ISRA_RECV && r.kind == ISRA_K_ADDR && fall
            && r.bitcnt == 4'h8 && r.shift[7:1] != own_addr && r.shift != 8'h00
            |=> r.phase == ISRA_IGNORE && sda_oe_n_o;
    endproperty
    a_mismatch_quiet: assert property (p_mismatch_quiet) else $error("foreign address answered");
    property p_nack_idle;
        ce_i && !r.shut && !bus_interface_shutdown_i && !start_c && !stop_c
            && r.phase == ISRA_MACK && rise && sda_s
            |=> r.phase == ISRA_IDLE ##1 sda_oe_n_o;
    endproperty
    a_nack_idle: assert property (p_nack_idle) else $error("read went on after nack");
    property p_shut_sticky;
        r.shut |=> r.shut [*8];
    endproperty
    a_shut_sticky: assert property (p_shut_sticky) else $error("shutdown left without reset");
    property p_shut_silent;
        r.shut |-> sda_oe_n_o && !r.push && !r.rd_strobe;
    endproperty
    a_shut_silent: assert property (p_shut_silent) else $error("shut interface touched bus");
    property p_shut_take;
        ce_i && !r.shut && rise && bus_interface_shutdown_i |=> r.shut && bus_shut_o;
    endproperty
    a_shut_take: assert property (p_shut_take) else $error("shutdown not taken on edge");
    property p_read_wrap;
        r.rd_strobe && $past(ce_i) && $past(r.ptr) == 8'h12 |-> r.ptr == 8'h00;
    endproperty
    a_read_wrap: assert property (p_read_wrap) else $error("pointer did not wrap");
    property p_read_inc;
        r.rd_strobe && $past(ce_i) && $past(r.ptr) == 8'h10 |-> r.ptr == 8'h11;
    endproperty
    a_read_inc: assert property (p_read_inc) else $error("pointer did not step");
    property p_noinc;
        r.rd_strobe && $past(ce_i) && $past(r.ptr) == 8'h09 |-> r.ptr == 8'h09;
    endproperty
    a_noinc: assert property (p_noinc) else $error("fixed pointer moved");
    property p_gc_reset;
        r.dev_reset |-> r.ptr == 8'h00 && r.phase == ISRA_ACK && !sda_oe_n_o;
    endproperty
    a_gc_reset: assert property (p_gc_reset) else $error("general call reset wrong");
    property p_write_push;
        r.push |-> r.phase == ISRA_ACK && !sda_oe_n_o
            && (r.push_word[15:8] != r.ptr || r.push_word[15:8] == 8'h09);
    endproperty
    a_write_push: assert property (p_write_push) else $error("stored byte not acked");
    c_read_nack: cover property (r.phase == ISRA_MACK && rise && sda_s);
    c_write: cover property (r.push);
    c_gc_reset: cover property (r.dev_reset);
    c_shut: cover property ($rose(r.shut));
endmodule : isra_slave

// [hdl/isra_sync.sv]
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module isra_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    // clock and control
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // pins in, synchronised out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } isra_sync_state_type;

    isra_sync_state_type st_reg;
    isra_sync_state_type st_next;

    always_comb begin
        st_next.meta = async_i;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            st_reg <= {INIT, INIT};
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    assign sync_o = st_reg.stable;
endmodule : isra_sync

// [inc/isra_defines.svh]
// constants of the serial register access front end
`ifndef ISRA_DEFINES_SVH
`define ISRA_DEFINES_SVH

// seven-bit slave addresses selected by the address strap
`define ISRA_DEV_SLAVE_ADDRESS_SELECT_INPUT 7'h41
`define ISRA_DEV_ADDR1 7'h44
// general call address byte and its second-byte commands
`define ISRA_GC_ADDR 8'h00
`define ISRA_GC_RESET 8'h06
`define ISRA_GC_LATCH 8'h04
// register space of the pointer
`define ISRA_FIRST_REG 8'h00
`define ISRA_LAST_REG 8'h12
`define ISRA_NOINC_REG 8'h09
// bit slot counts
`define ISRA_BYTE_BITS 4'h8
`define ISRA_ACKED 4'h9
// write path buffer
`define ISRA_FIFO_DEPTH 8
`define ISRA_WORD_BITS 16

`endif

// [inc/isra_pkg.sv]
// types of the serial register access front end
package isra_pkg;

    typedef enum logic [2:0] {
        ISRA_IDLE = 3'b000,
        ISRA_RECV = 3'b001,
        ISRA_ACK = 3'b010,
        ISRA_SEND = 3'b011,
        ISRA_MACK = 3'b100,
        ISRA_IGNORE = 3'b101
    } isra_phase_type;

    typedef enum logic [2:0] {
        ISRA_K_ADDR = 3'b000,
        ISRA_K_REG = 3'b001,
        ISRA_K_DATA = 3'b010,
        ISRA_K_GC = 3'b011,
        ISRA_K_READ = 3'b100,
        ISRA_K_NONE = 3'b101
    } isra_kind_type;

    typedef struct packed {
        isra_phase_type phase;
        isra_kind_type kind;
        logic [3:0] bitcnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic sda_oe_n;
        logic shut;
        logic addr_sel;
        logic strap_taken;
        logic scl_d;
        logic sda_d;
        logic dev_reset;
        logic rd_strobe;
        logic push;
        logic [15:0] push_word;
    } isra_slave_state_type;

endpackage : isra_pkg
